/* src/electrode_lead_off_detect.sv */
// Digital lead-off detection: dc debounce, ac carrier demodulation, adc range flags.
// Assumes comparator levels and adc samples are synchronous to i_clk and that
// the serial interface decoder drives the register index port.
`timescale 1ns/100ps

// Notes on behaviour
// - 8-bit saturating up/down counter at 2 kHz
// - Count up while open, down otherwise
// - DC flag set only at all ones
// - Detection to indication latency is 255 ticks, 127.5 ms
// - Flag clears only after counter reaches zero
// - Debounce fixed and always enabled
// - Single fixed 2.039 kHz carrier
// - Per-electrode polarity bits 23:18, programmable amplitude
// - AC drive only on six electrode inputs
// - I/Q demodulate, detect amplitude, filter, compare
// - Shared upper and lower thresholds
// - Amplitude above upper threshold flags lead-off
// - Amplitude below lower threshold flags lead-off
// - Amplitudes readable at indices 0x31 to 0x35
// - Result follows electrode or lead channel data
// - Amplitude includes channel gain
// - Calibration DAC enabled disables AC detection
// - AC lead-off flag within 10 ms
// - ADC range flags from programmable thresholds
// - Range flag in frame header word
// - Header lead-off flag plus per-electrode status
// - Comparator trips above 2.4 V or below 0.2 V
module electrode_lead_off_detect
   import lead_off_pkg::*;
#(
   parameter int unsigned TICK_DIV   = TICK_CYCLES,
   parameter int unsigned DATA_W     = 24,
   parameter int unsigned WIN_LOG    = 4,
   parameter int unsigned FILT_SHIFT = 2
) (
   // Clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_srst,
   // Register port from the serial interface decoder
   input  wire logic [5:0]                i_reg_addr,
   input  wire logic                      i_reg_wr,
   input  wire logic [31:0]               i_reg_wdata,
   output logic      [31:0]               o_reg_rdata,
   // Analog front end
   input  wire logic [N_ELEC-1:0]         i_dc_cmp_high,
   input  wire logic [N_ELEC-1:0]         i_dc_cmp_low,
   input  wire logic                      i_rld_cmp_fault,
   input  wire logic                      i_cal_dac_en,
   output logic      [N_ELEC-1:0]         o_ac_drive,
   output logic      [CTL_AMP_W-1:0]      o_ac_drive_amp,
   output logic                           o_dc_inject_en,
   // Digitized channel samples, post gain
   input  wire logic                      i_sample_valid,
   input  wire logic [N_CHAN*DATA_W-1:0]  i_sample_data,
   // Frame header, per-electrode and per-channel flags
   output logic                           o_hdr_lead_off,
   output logic                           o_hdr_adc_range,
   output logic      [N_ELEC-1:0]         o_dc_lead_off,
   output logic      [N_CHAN-1:0]         o_ac_lead_off,
   output logic      [N_CHAN-1:0]         o_adc_range
);

   localparam int unsigned ACC_W = DATA_W + WIN_LOG + 1;

   function automatic logic [ACC_W-1:0] abs_acc(input logic signed [ACC_W-1:0] v);
      abs_acc = v[ACC_W-1] ? ACC_W'(-v) : ACC_W'(v);
   endfunction : abs_acc

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] control_r,    control_nxt;
   logic [31:0] upper_r,      upper_nxt;
   logic [31:0] lower_r,      lower_nxt;
   logic        ac_active;

   always_comb begin
      control_nxt = control_r;
      upper_nxt   = upper_r;
      lower_nxt   = lower_r;
      if (i_reg_wr) begin
         if (i_reg_addr == ADDR_CONTROL) begin
            control_nxt = i_reg_wdata;
         end else if (i_reg_addr == ADDR_UPPER) begin
            upper_nxt = i_reg_wdata;
         end else if (i_reg_addr == ADDR_LOWER) begin
            lower_nxt = i_reg_wdata;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         control_r <= CTL_RESET;
         upper_r   <= UPPER_RESET;
         lower_r   <= LOWER_RESET;
      end else begin
         control_r <= control_nxt;
         upper_r   <= upper_nxt;
         lower_r   <= lower_nxt;
      end
   end

   assign ac_active = control_r[CTL_AC_EN] & ~i_cal_dac_en;

   // ----------------------------------------------------------------
   // 2 kHz tick and dc debounce
   // ----------------------------------------------------------------
   logic [31:0]       tick_cnt_r, tick_cnt_nxt;
   logic              tick;
   logic [DEB_W-1:0]  deb_r [N_ELEC];
   logic [DEB_W-1:0]  deb_nxt [N_ELEC];
   logic [N_ELEC-1:0] dc_flag_r, dc_flag_nxt;
   logic [N_ELEC-1:0] open_elec;

   assign tick      = (tick_cnt_r == 32'(TICK_DIV - 1));
   assign open_elec = i_dc_cmp_high | i_dc_cmp_low;

   always_comb begin
      tick_cnt_nxt = tick ? '0 : tick_cnt_r + 32'd1;
      dc_flag_nxt  = dc_flag_r;
      for (int e = 0; e < N_ELEC; e++) begin
         deb_nxt[e] = deb_r[e];
         if (tick) begin
            if (open_elec[e]) begin
               if (deb_r[e] != DEB_FULL) deb_nxt[e] = deb_r[e] + 8'h01;
            end else if (deb_r[e] != DEB_EMPTY) begin
               deb_nxt[e] = deb_r[e] - 8'h01;
            end
         end
         if (deb_r[e] == DEB_FULL) begin
            dc_flag_nxt[e] = 1'b1;
         end else if (deb_r[e] == DEB_EMPTY) begin
            dc_flag_nxt[e] = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         tick_cnt_r <= '0;
         dc_flag_r  <= '0;
         for (int e = 0; e < N_ELEC; e++) deb_r[e] <= DEB_EMPTY;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         dc_flag_r  <= dc_flag_nxt;
         for (int e = 0; e < N_ELEC; e++) deb_r[e] <= deb_nxt[e];
      end
   end

   // ----------------------------------------------------------------
   // Carrier generator and electrode drive
   // ----------------------------------------------------------------
   logic [PHASE_W-1:0] phase_r, phase_nxt;
   logic               carr_i;
   logic               carr_q;

   assign phase_nxt = phase_r + CARRIER_INC;
   assign carr_i    = phase_r[PHASE_W-1];
   assign carr_q    = phase_r[PHASE_W-1] ^ phase_r[PHASE_W-2];

   always_ff @(posedge i_clk) begin
      if (i_srst) phase_r <= '0;
      else        phase_r <= phase_nxt;
   end

   logic [N_ELEC-1:0]    drive_nxt;
   logic [CTL_AMP_W-1:0] drive_amp_nxt;
   logic                 inject_nxt;

   // Drive is parked low whenever the ac path is inactive
   always_comb begin
      drive_nxt     = '0;
      drive_amp_nxt = control_r[CTL_AMP_LSB +: CTL_AMP_W];
      inject_nxt    = control_r[CTL_DC_EN];
      if (ac_active) begin
         drive_nxt = {N_ELEC{carr_i}} ^ control_r[CTL_POL_LSB +: N_ELEC];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_ac_drive     <= '0;
         o_ac_drive_amp <= '0;
         o_dc_inject_en <= 1'b0;
      end else begin
         o_ac_drive     <= drive_nxt;
         o_ac_drive_amp <= drive_amp_nxt;
         o_dc_inject_en <= inject_nxt;
      end
   end

   // ----------------------------------------------------------------
   // I/Q demodulation, amplitude filter, thresholds
   // ----------------------------------------------------------------
   logic signed [ACC_W-1:0]  acc_i_r [N_CHAN];
   logic signed [ACC_W-1:0]  acc_i_nxt [N_CHAN];
   logic signed [ACC_W-1:0]  acc_q_r [N_CHAN];
   logic signed [ACC_W-1:0]  acc_q_nxt [N_CHAN];
   logic        [DATA_W-1:0] filt_r [N_CHAN];
   logic        [DATA_W-1:0] filt_nxt [N_CHAN];
   logic        [WIN_LOG-1:0] win_r, win_nxt;
   logic        [N_CHAN-1:0] ac_flag_r, ac_flag_nxt;
   logic        [N_CHAN-1:0] range_r, range_nxt;

   always_comb begin
      logic signed [ACC_W-1:0]  samp;
      logic        [ACC_W-1:0]  mag;
      logic        [DATA_W-1:0] amp;
      logic signed [DATA_W:0]   diff;
      logic        [TH_W-1:0]   top;
      samp        = '0;
      mag         = '0;
      amp         = '0;
      diff        = '0;
      top         = '0;
      win_nxt     = win_r;
      ac_flag_nxt = ac_flag_r;
      range_nxt   = range_r;
      if (i_sample_valid) win_nxt = win_r + WIN_LOG'(1);
      for (int c = 0; c < N_CHAN; c++) begin
         acc_i_nxt[c] = acc_i_r[c];
         acc_q_nxt[c] = acc_q_r[c];
         filt_nxt[c]  = filt_r[c];
         samp = ACC_W'($signed(i_sample_data[c*DATA_W +: DATA_W]));
         if (i_sample_valid) begin
            range_nxt[c] =
               ($signed(samp[DATA_W-1 -: TH_W]) > $signed(upper_r[TH_ADC_LSB +: TH_W])) ||
               ($signed(samp[DATA_W-1 -: TH_W]) < $signed(lower_r[TH_ADC_LSB +: TH_W]));
            acc_i_nxt[c] = acc_i_r[c] + (carr_i ? -samp : samp);
            acc_q_nxt[c] = acc_q_r[c] + (carr_q ? -samp : samp);
            if (win_r == '1) begin
               mag  = (abs_acc(acc_i_nxt[c]) + abs_acc(acc_q_nxt[c])) >> WIN_LOG;
               amp  = DATA_W'(mag);
               diff = $signed({1'b0, amp}) - $signed({1'b0, filt_r[c]});
               filt_nxt[c]  = DATA_W'($signed({1'b0, filt_r[c]}) + (diff >>> FILT_SHIFT));
               acc_i_nxt[c] = '0;
               acc_q_nxt[c] = '0;
            end
         end
         top = filt_r[c][DATA_W-1 -: TH_W];
         ac_flag_nxt[c] = ac_active &&
            ((top > upper_r[TH_AC_LSB +: TH_W]) ||
             (top < lower_r[TH_AC_LSB +: TH_W]));
         if (!ac_active) begin
            acc_i_nxt[c] = '0;
            acc_q_nxt[c] = '0;
            filt_nxt[c]  = '0;
         end
      end
      if (!ac_active) win_nxt = '0;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         win_r     <= '0;
         ac_flag_r <= '0;
         range_r   <= '0;
         for (int c = 0; c < N_CHAN; c++) begin
            acc_i_r[c] <= '0;
            acc_q_r[c] <= '0;
            filt_r[c]  <= '0;
         end
      end else begin
         win_r     <= win_nxt;
         ac_flag_r <= ac_flag_nxt;
         range_r   <= range_nxt;
         for (int c = 0; c < N_CHAN; c++) begin
            acc_i_r[c] <= acc_i_nxt[c];
            acc_q_r[c] <= acc_q_nxt[c];
            filt_r[c]  <= filt_nxt[c];
         end
      end
   end

   // ----------------------------------------------------------------
   // Header flags and register read
   // ----------------------------------------------------------------
   assign o_dc_lead_off   = dc_flag_r;
   assign o_ac_lead_off   = ac_flag_r;
   assign o_adc_range     = range_r;
   assign o_hdr_lead_off  = (|dc_flag_r) | (|ac_flag_r) | i_rld_cmp_fault;
   assign o_hdr_adc_range = |range_r;

   always_comb begin
      o_reg_rdata = 32'h0000_0000;
      if (i_reg_addr == ADDR_CONTROL) begin
         o_reg_rdata = control_r;
      end else if (i_reg_addr == ADDR_UPPER) begin
         o_reg_rdata = upper_r;
      end else if (i_reg_addr == ADDR_LOWER) begin
         o_reg_rdata = lower_r;
      end else if (i_reg_addr == ADDR_STATUS) begin
         o_reg_rdata[ST_DC_LSB +: N_ELEC]    = dc_flag_r;
         o_reg_rdata[ST_RLD]                 = i_rld_cmp_fault;
         o_reg_rdata[ST_AC_LSB +: N_CHAN]    = ac_flag_r;
         o_reg_rdata[ST_RANGE_LSB +: N_CHAN] = range_r;
      end else if (i_reg_addr >= ADDR_AMP_FIRST && i_reg_addr <= ADDR_AMP_LAST) begin
         o_reg_rdata[DATA_W-1:0] = filt_r[3'(i_reg_addr - ADDR_AMP_FIRST)];
      end
   end

endmodule : electrode_lead_off_detect

/* src/lead_off_pkg.sv */
// Constants shared by the lead-off detection block.
// Assumes a 50 MHz system clock and registers addressed by index from the serial decoder.
package lead_off_pkg;

   // ----------------------------------------------------------------
   // Clock and timebases
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned TICK_HZ       = 2_000;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / TICK_HZ;
   localparam int unsigned DEBOUNCE_MS   = 125;
   localparam int unsigned CARRIER_MHZ   = 2_039_000;
   localparam int unsigned PHASE_W       = 32;
   localparam logic [31:0] CARRIER_INC   =
      32'((64'(CARRIER_MHZ) << PHASE_W) / (64'(CLK_HZ) * 64'd1000));

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int unsigned N_ELEC        = 6;
   localparam int unsigned N_CHAN        = 5;
   localparam int unsigned DEB_W         = 8;
   localparam logic [7:0]  DEB_FULL      = 8'hFF;
   localparam logic [7:0]  DEB_EMPTY     = 8'h00;

   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [5:0]  ADDR_CONTROL  = 6'h10;
   localparam logic [5:0]  ADDR_UPPER    = 6'h11;
   localparam logic [5:0]  ADDR_LOWER    = 6'h12;
   localparam logic [5:0]  ADDR_STATUS   = 6'h13;
   localparam logic [5:0]  ADDR_AMP_FIRST= 6'h31;
   localparam logic [5:0]  ADDR_AMP_LAST = 6'h35;

   // ----------------------------------------------------------------
   // Control register fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTL_AC_EN     = 0;
   localparam int unsigned CTL_DC_EN     = 1;
   localparam int unsigned CTL_AMP_LSB   = 2;
   localparam int unsigned CTL_AMP_W     = 2;
   localparam int unsigned CTL_POL_LSB   = 18;
   localparam logic [31:0] CTL_RESET     = 32'h0000_0000;
   localparam logic [31:0] UPPER_RESET   = 32'h7FFF_FFFF;
   localparam logic [31:0] LOWER_RESET   = 32'h8000_0000;

   // Threshold fields: low half for ac amplitude, high half for adc range
   localparam int unsigned TH_W          = 16;
   localparam int unsigned TH_AC_LSB     = 0;
   localparam int unsigned TH_ADC_LSB    = 16;

   // Status register fields
   localparam int unsigned ST_DC_LSB     = 0;
   localparam int unsigned ST_RLD        = 6;
   localparam int unsigned ST_AC_LSB     = 8;
   localparam int unsigned ST_RANGE_LSB  = 16;

endpackage : lead_off_pkg

/* verification/lead_off_sva.sv */
// Checker for the lead-off block, watching its ports only.
// Assumes it is bound into electrode_lead_off_detect.
`timescale 1ns/100ps
module lead_off_sva
   import lead_off_pkg::*;
#(parameter int unsigned TICK_DIV = TICK_CYCLES) (
   input wire logic              i_clk,
   input wire logic              i_srst,
   input wire logic              i_reg_wr,
   input wire logic [N_ELEC-1:0] i_dc_cmp_high,
   input wire logic [N_ELEC-1:0] i_dc_cmp_low,
   input wire logic              i_rld_cmp_fault,
   input wire logic              i_cal_dac_en,
   input wire logic              i_sample_valid,
   input wire logic [N_ELEC-1:0] o_ac_drive,
   input wire logic [1:0]        o_ac_drive_amp,
   input wire logic              o_dc_inject_en,
   input wire logic              o_hdr_lead_off,
   input wire logic              o_hdr_adc_range,
   input wire logic [N_ELEC-1:0] o_dc_lead_off,
   input wire logic [N_CHAN-1:0] o_ac_lead_off,
   input wire logic [N_CHAN-1:0] o_adc_range
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // Mirror of the debounce tick, and cycles since the last one
   logic [31:0] tcnt_r, tcnt_nxt;
   logic [3:0]  since_r, since_nxt;
   logic [N_ELEC-1:0] open;
   assign open = i_dc_cmp_high | i_dc_cmp_low;
   always_comb begin
      tcnt_nxt  = (tcnt_r == TICK_DIV - 1) ? 32'h0 : tcnt_r + 32'h1;
      since_nxt = (tcnt_r == TICK_DIV - 1) ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
   end
   always_ff @(posedge i_clk) begin
      tcnt_r  <= i_srst ? 32'h0 : tcnt_nxt;
      since_r <= i_srst ? 4'hF : since_nxt;
   end
   property p_hdr_or;
      o_hdr_lead_off == (|o_dc_lead_off || |o_ac_lead_off || i_rld_cmp_fault);
   endproperty
   a_hdr_or: assert property (p_hdr_or) else $error("header lead-off flag wrong");
   property p_rng_or;
      o_hdr_adc_range == |o_adc_range;
   endproperty
   a_rng_or: assert property (p_rng_or) else $error("header range flag wrong");
   property p_dc_tick;
      !$stable(o_dc_lead_off) |-> since_r < 4'h5;
   endproperty
   a_dc_tick: assert property (p_dc_tick) else $error("dc flag moved off tick");
   property p_dc_rise;
      (o_dc_lead_off & ~$past(o_dc_lead_off) & ~$past(open, 2)) == '0;
   endproperty
   a_dc_rise: assert property (p_dc_rise) else $error("dc flag set while closed");
   property p_dc_fall;
      (~o_dc_lead_off & $past(o_dc_lead_off) & $past(open, 2)) == '0;
   endproperty
   a_dc_fall: assert property (p_dc_fall) else $error("dc flag cleared while open");
   property p_cal_off;
      i_cal_dac_en |=> o_ac_drive == '0 && o_ac_lead_off == '0;
   endproperty
   a_cal_off: assert property (p_cal_off) else $error("ac path live under cal");
   property p_rng_hold;
      !i_sample_valid |=> $stable(o_adc_range);
   endproperty
   a_rng_hold: assert property (p_rng_hold) else $error("range flag without sample");
   property p_ac_hold;
      !$stable(o_ac_lead_off) |->
         $past(i_sample_valid, 2) || ($past(i_cal_dac_en) != $past(i_cal_dac_en, 2)) ||
         $past(i_reg_wr, 2);
   endproperty
   a_ac_hold: assert property (p_ac_hold) else $error("ac flag without cause");
   property p_ctl_hold;
      !$stable({o_ac_drive_amp, o_dc_inject_en}) |-> $past(i_reg_wr) || $past(i_reg_wr, 2);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold) else $error("control out without write");
   c_dc_set: cover property ($rose(o_dc_lead_off[0]));
   c_ac_set: cover property ($rose(|o_ac_lead_off));
   c_rng_set: cover property ($rose(o_hdr_adc_range));
endmodule : lead_off_sva

bind electrode_lead_off_detect lead_off_sva #(.TICK_DIV(TICK_DIV)) lead_off_sva_i (
   .i_clk(i_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr), .i_dc_cmp_high(i_dc_cmp_high),
   .i_dc_cmp_low(i_dc_cmp_low), .i_rld_cmp_fault(i_rld_cmp_fault),
   .i_cal_dac_en(i_cal_dac_en), .i_sample_valid(i_sample_valid), .o_ac_drive(o_ac_drive),
   .o_ac_drive_amp(o_ac_drive_amp), .o_dc_inject_en(o_dc_inject_en),
   .o_hdr_lead_off(o_hdr_lead_off), .o_hdr_adc_range(o_hdr_adc_range),
   .o_dc_lead_off(o_dc_lead_off), .o_ac_lead_off(o_ac_lead_off), .o_adc_range(o_adc_range));

/* verification/lead_off_host.sv */
// Host controller model: register port master and flag reader.
// Assumes the same clock as the device.
`timescale 1ns/100ps
module lead_off_host
   import lead_off_pkg::*;
(
   // Clock
   input  wire logic              i_clk,
   // Register port
   output logic [5:0]             o_reg_addr,
   output logic                   o_reg_wr,
   output logic [31:0]            o_reg_wdata,
   input  wire logic [31:0]       i_reg_rdata,
   // Flags
   input  wire logic [N_CHAN-1:0] i_ac_lead_off,
   input  wire logic [N_CHAN-1:0] i_adc_range,
   output logic [N_CHAN-1:0]      o_chan_off
);
   initial begin
      o_reg_addr = 6'h3F;
      o_reg_wr = 1'b0;
      o_reg_wdata = 32'h0;
   end
   assign o_chan_off = i_ac_lead_off | i_adc_range;
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge i_clk);
      #1;
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(posedge i_clk);
      #1;
      o_reg_wr = 1'b0;
      o_reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge i_clk);
      #1;
      o_reg_addr = a;
      @(negedge i_clk);
      d = i_reg_rdata;
      @(posedge i_clk);
   endtask : rd
endmodule : lead_off_host

/* verification/electrode_lead_off_detect_tb_top.sv */
// Testbench for the lead-off block with a host model on the register port.
// Assumes a short debounce tick divider in simulation.
`timescale 1ns/100ps
module electrode_lead_off_detect_tb_top;
   import lead_off_pkg::*;
   localparam int unsigned TD = 10;
   logic                 clk, rw, hl, hr, inj;
   logic                 srst = 1'b1, rld = 1'b0, cal = 1'b0, sv = 1'b0;
   logic [N_ELEC-1:0]    hi = '0, lo = '0, dco, drv;
   logic [N_CHAN-1:0]    aco, rng, off;
   logic [N_CHAN*24-1:0] sd = '0;
   logic [5:0]           ra;
   logic [1:0]           amp;
   logic [31:0]          rwd, rrd, v;
   int                   n_fail = 0, n_checks = 0, cyc = 0, k;
   electrode_lead_off_detect #(.TICK_DIV(TD)) electrode_lead_off_detect_i (
      .i_clk(clk), .i_srst(srst), .i_reg_addr(ra), .i_reg_wr(rw), .i_reg_wdata(rwd),
      .o_reg_rdata(rrd), .i_dc_cmp_high(hi), .i_dc_cmp_low(lo), .i_rld_cmp_fault(rld),
      .i_cal_dac_en(cal), .o_ac_drive(drv), .o_ac_drive_amp(amp), .o_dc_inject_en(inj),
      .i_sample_valid(sv), .i_sample_data(sd), .o_hdr_lead_off(hl), .o_hdr_adc_range(hr),
      .o_dc_lead_off(dco), .o_ac_lead_off(aco), .o_adc_range(rng));
   lead_off_host lead_off_host_i (
      .i_clk(clk), .o_reg_addr(ra), .o_reg_wr(rw), .o_reg_wdata(rwd), .i_reg_rdata(rrd),
      .i_ac_lead_off(aco), .i_adc_range(rng), .o_chan_off(off));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         n_fail++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic wait_dc(input logic want, input int lim);
      for (int i = 0; i < lim && dco[0] !== want; i++) @(posedge clk);
      chk(dco[0], want, "dc flag wait");
   endtask : wait_dc
   task automatic samples(input int n, input bit car);
      repeat (n) begin
         repeat (3) @(posedge clk);
         #1;
         sd = car ? {N_CHAN{drv[0] ? 24'h7FFF00 : 24'h800100}} : '0;
         sv = 1'b1;
         @(posedge clk);
         #1;
         sv = 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask : samples
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      lead_off_host_i.rd(ADDR_UPPER, v);
      chk(v, UPPER_RESET, "upper reset");
      lead_off_host_i.rd(ADDR_LOWER, v);
      chk(v, LOWER_RESET, "lower reset");
      lead_off_host_i.wr(ADDR_AMP_FIRST, 32'hFFFF_FFFF);
      for (int a = 'h31; a <= 'h35; a++) begin
         lead_off_host_i.rd(6'(a), v);
         chk(v, 32'h0, "amplitude idle");
      end
      lead_off_host_i.rd(6'h3F, v);
      chk(v, 32'h0, "unmapped");
      #1;
      rld = 1'b1;
      lead_off_host_i.rd(ADDR_STATUS, v);
      chk({v[ST_RLD], hl, aco}, 7'h60, "rld fault");
      #1;
      rld = 1'b0;
   endtask : t_regs
   task automatic t_dc();
      #1;
      hi = 6'h01;
      repeat (125 * TD) @(posedge clk);
      #1;
      hi = 6'h00;
      lo = 6'h01;
      repeat (125 * TD) @(posedge clk);
      chk(dco, 6'h00, "dc early");
      wait_dc(1'b1, 8 * TD);
      lead_off_host_i.rd(ADDR_STATUS, v);
      chk({hl, v[5:0]}, 7'h41, "dc status");
      #1;
      lo = 6'h00;
      repeat (250 * TD) @(posedge clk);
      chk(dco, 6'h01, "dc held");
      wait_dc(1'b0, 8 * TD);
   endtask : t_dc
   task automatic t_range();
      lead_off_host_i.wr(ADDR_UPPER, 32'h0100_FFFF);
      lead_off_host_i.wr(ADDR_LOWER, 32'hFF00_0010);
      #1;
      sd[2*24 +: 24] = 24'h020000;
      sd[4*24 +: 24] = 24'hFE0000;
      sv = 1'b1;
      @(posedge clk);
      #1;
      sv = 1'b0;
      @(posedge clk);
      #1;
      chk({aco, rng, off}, 15'h0294, "range flags");
      chk(hr, 1'b1, "range header");
   endtask : t_range
   task automatic t_ac();
      lead_off_host_i.wr(ADDR_CONTROL, 32'h0008_000F);
      lead_off_host_i.wr(ADDR_UPPER, 32'h0100_0001);
      chk({inj, amp, drv[1]}, {3'h7, ~drv[0]}, "drive setup");
      samples(160, 1'b1);
      chk({aco, hl}, 6'h3F, "above upper");
      lead_off_host_i.rd(ADDR_AMP_FIRST, v);
      chk(v != 32'h0, 1'b1, "amplitude value");
      #1;
      cal = 1'b1;
      repeat (2) @(posedge clk);
      chk({drv, aco}, 11'h0, "cal disable");
      #1;
      cal = 1'b0;
      lead_off_host_i.wr(ADDR_UPPER, 32'h0100_FFFF);
      samples(160, 1'b1);
      chk(aco, 5'h00, "in window");
      samples(600, 1'b0);
      chk(aco, 5'h1F, "below lower");
      @(posedge drv[1]);
      k = cyc;
      @(negedge drv[1]);
      // Half period in 20 ns cycles times 2039 Hz times 40 is 1e9 for an exact carrier
      chk((cyc - k) * 2039 * 40 >= 999_000_000 && (cyc - k) * 2039 * 40 <= 1_001_000_000,
          1'b1, "carrier half period");
   endtask : t_ac
   initial begin
      repeat (2) @(posedge clk);
      #1;
      srst = 1'b0;
      t_regs();
      t_dc();
      t_range();
      t_ac();
      close_out();
   end
endmodule : electrode_lead_off_detect_tb_top
